/* File: rtl/fdp_params.svh */
// offsets, field positions, reset values and codes of the floppy pin block
`ifndef FDP_PARAMS_SVH
`define FDP_PARAMS_SVH

// register byte offsets
`define FDP_OFS_DOR 8'h00
`define FDP_OFS_CFG 8'h04
`define FDP_OFS_DIN 8'h08
`define FDP_OFS_ISTAT 8'h0C
`define FDP_OFS_ICLR 8'h10
`define FDP_OFS_IEN 8'h14

// digital output register fields
`define FDP_DOR_DMA_EN 3
`define FDP_DOR_RST 8'h00

// configuration register fields
`define FDP_CFG_READ_GATE_DIAG 0
`define FDP_CFG_PDM 1
`define FDP_CFG_PNF 2
`define FDP_CFG_HEAD 3
`define FDP_CFG_W 4
`define FDP_CFG_RST 4'h0

// digital input register fields
`define FDP_DIN_DOOR 7
`define FDP_DIN_SYS2 0
`define FDP_DIN_BADSTRAP 1

// interrupt status fields
`define FDP_IRQ_DOOR 0
`define FDP_IRQ_ACK 1
`define FDP_IRQ_STRAP 2
`define FDP_IRQ_W 3
`define FDP_IRQ_RST 3'h0

// bus answers
`define FDP_RESP_OKAY 2'h0
`define FDP_RESP_SLVERR 2'h2

`endif

/* File: rtl/fdp_pkg.sv */
// types shared by the floppy drive, dma and pin logic
package fdp_pkg;

  typedef enum logic {
    FDP_MODE_LEGACY = 1'b0,
    FDP_MODE_SYS2 = 1'b1
  } fdp_mode_e;

  typedef enum logic [2:0] {
    FDP_SEL_DOR = 3'b000,
    FDP_SEL_CFG = 3'b001,
    FDP_SEL_DIN = 3'b010,
    FDP_SEL_ISTAT = 3'b011,
    FDP_SEL_ICLR = 3'b100,
    FDP_SEL_IEN = 3'b101,
    FDP_SEL_NONE = 3'b111
  } fdp_sel_e;

  // pin outputs toward drive, dma controller and the controller core
  typedef struct packed {
    logic floppy_dma_req;
    logic dma_ack_ok;
    logic dma_rd;
    logic dma_wr;
    logic head_side_select;
    logic pp_head_out;
    logic pp_head_oe_n;
    logic read_gate_diag;
    logic irq;
  } fdp_pins_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] digital_output_reg;
    logic [3:0] cfg;
    logic [2:0] irq_en;
    logic [2:0] irq_stat;
    logic strap_done;
    fdp_mode_e mode;
    logic strap_bad;
    logic door_q;
    logic ack_q;
    fdp_pins_s pins;
  } fdp_state_s;

endpackage

/* File: rtl/fdp_top.sv */
// floppy disk-change, dma request/acknowledge, head select and strap logic
//
// How it works
// - The door-opened level is readable in the digital input register.
// - A configuration bit reroutes the door input to the read-gate diagnostic output.
// - In parallel-drive mode with floppy select 0 a second door input on a shared pin counts.
// - The low-active dma acknowledge answers the request and qualifies read and write strobes.
// - In legacy mode the acknowledge is honoured only while digital output bit 3 is set.
// - In system-2 mode the acknowledge is always enabled and bit 3 is reserved.
// - The dma request goes high when the controller needs a transfer serviced and the request path is enabled.
// - The request is gated by bit 3 in legacy mode and always enabled in system-2 mode.
// - Head select is active for side 1 and inactive for side 0.
// - In parallel-drive mode with floppy select 0 head select is also driven on a shared pin.
// - Identity and encoding straps pick legacy, system-2 or the illegal combination.
`timescale 1ns/1ps
`include "fdp_params.svh"

module fdp_top
  import fdp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // straps
  input wire logic ident_strap,
  input wire logic encoding_strap,
  // drive pins
  input wire logic door_opened_in,
  input wire logic door_opened_pp_in,
  output logic head_side_select,
  output logic pp_head_out,
  output logic pp_head_oe_n,
  // dma controller pins
  output logic floppy_dma_req,
  input wire logic floppy_dma_ack_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  // controller core side
  input wire logic xfer_demand,
  output logic dma_ack_ok,
  output logic dma_rd,
  output logic dma_wr,
  output logic read_gate_diag,
  // interrupt
  output logic irq
);

  fdp_state_s state_reg;
  fdp_state_s state_next;

  function automatic fdp_sel_e fdp_decode(input logic [7:0] addr);
    fdp_sel_e sel;
    sel = FDP_SEL_NONE;
    if (addr == `FDP_OFS_DOR) begin
      sel = FDP_SEL_DOR;
    end else if (addr == `FDP_OFS_CFG) begin
      sel = FDP_SEL_CFG;
    end else if (addr == `FDP_OFS_DIN) begin
      sel = FDP_SEL_DIN;
    end else if (addr == `FDP_OFS_ISTAT) begin
      sel = FDP_SEL_ISTAT;
    end else if (addr == `FDP_OFS_ICLR) begin
      sel = FDP_SEL_ICLR;
    end else if (addr == `FDP_OFS_IEN) begin
      sel = FDP_SEL_IEN;
    end
    return sel;
  endfunction

  always_comb begin
    logic sys2;
    logic dma_gate;
    logic pp_on;
    logic door_lvl;
    logic ack_now;
    logic do_wr;
    fdp_sel_e wsel;
    fdp_sel_e rsel;
    logic [2:0] set_ev;
    logic [2:0] clr_ev;
    logic [31:0] rd_val;
    sys2 = 1'b0;
    dma_gate = 1'b0;
    pp_on = 1'b0;
    door_lvl = 1'b0;
    ack_now = 1'b0;
    do_wr = 1'b0;
    wsel = FDP_SEL_NONE;
    rsel = FDP_SEL_NONE;
    set_ev = 3'h0;
    clr_ev = 3'h0;
    rd_val = 32'h0;
    state_next = state_reg;

    // straps are taken at the first edge after reset release
    if (!state_reg.strap_done) begin
      state_next.strap_done = 1'b1;
      if (!ident_strap) begin
        state_next.mode = FDP_MODE_SYS2;
      end else begin
        state_next.mode = FDP_MODE_LEGACY;
      end
      // illegal pair falls back to legacy but is flagged
      state_next.strap_bad = ident_strap && !encoding_strap;
      set_ev[`FDP_IRQ_STRAP] = ident_strap && !encoding_strap;
    end

    sys2 = (state_reg.mode == FDP_MODE_SYS2);
    dma_gate = sys2 || state_reg.digital_output_reg[`FDP_DOR_DMA_EN];
    pp_on = state_reg.cfg[`FDP_CFG_PDM] && !state_reg.cfg[`FDP_CFG_PNF];

    // either drive's door counts in parallel-drive mode
    door_lvl = door_opened_in || (pp_on && door_opened_pp_in);
    state_next.door_q = door_lvl;
    if (state_reg.strap_done && (door_lvl != state_reg.door_q)) begin
      set_ev[`FDP_IRQ_DOOR] = 1'b1;
    end

    // acknowledge only counts while the request path is enabled
    ack_now = !floppy_dma_ack_n && dma_gate;
    state_next.ack_q = ack_now;
    set_ev[`FDP_IRQ_ACK] = ack_now && !state_reg.ack_q;

    state_next.pins.floppy_dma_req = xfer_demand && dma_gate;
    state_next.pins.dma_ack_ok = ack_now;
    state_next.pins.dma_rd = ack_now && !host_rd_n;
    state_next.pins.dma_wr = ack_now && !host_wr_n;
    state_next.pins.head_side_select = state_reg.cfg[`FDP_CFG_HEAD];
    state_next.pins.pp_head_out = state_reg.cfg[`FDP_CFG_HEAD] && pp_on;
    state_next.pins.pp_head_oe_n = !pp_on;
    // diagnostic reroute: door pin feeds the data separator gate
    state_next.pins.read_gate_diag = state_reg.cfg[`FDP_CFG_READ_GATE_DIAG] && door_opened_in;

    // write address and data are taken independently
    if (s_axi_awvalid && state_reg.awready) begin
      state_next.aw_held = 1'b1;
      state_next.awaddr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && state_reg.wready) begin
      state_next.w_held = 1'b1;
      state_next.wdata = s_axi_wdata[7:0];
      state_next.wstrb0 = s_axi_wstrb[0];
    end
    do_wr = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
    if (do_wr) begin
      wsel = fdp_decode(state_reg.awaddr);
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = `FDP_RESP_OKAY;
      if (wsel == FDP_SEL_NONE) begin
        state_next.bresp = `FDP_RESP_SLVERR;
      end else if (!state_reg.wstrb0) begin
        state_next.bresp = `FDP_RESP_OKAY;
      end else if (wsel == FDP_SEL_DOR) begin
        state_next.digital_output_reg = state_reg.wdata;
        // bit 3 is reserved in system-2 mode and stays clear
        if (sys2) begin
          state_next.digital_output_reg[`FDP_DOR_DMA_EN] = 1'b0;
        end
      end else if (wsel == FDP_SEL_CFG) begin
        state_next.cfg = state_reg.wdata[`FDP_CFG_W-1:0];
      end else if (wsel == FDP_SEL_ICLR) begin
        clr_ev = state_reg.wdata[`FDP_IRQ_W-1:0];
      end else if (wsel == FDP_SEL_IEN) begin
        state_next.irq_en = state_reg.wdata[`FDP_IRQ_W-1:0];
      end
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    state_next.awready = !state_next.aw_held && !state_next.bvalid;
    state_next.wready = !state_next.w_held && !state_next.bvalid;

    // read: one address taken, answer on the next edge
    if (s_axi_arvalid && state_reg.arready) begin
      rsel = fdp_decode(s_axi_araddr[7:0]);
      state_next.rvalid = 1'b1;
      state_next.rresp = `FDP_RESP_OKAY;
      if (rsel == FDP_SEL_DOR) begin
        rd_val[7:0] = state_reg.digital_output_reg;
      end else if (rsel == FDP_SEL_CFG) begin
        rd_val[`FDP_CFG_W-1:0] = state_reg.cfg;
      end else if (rsel == FDP_SEL_DIN) begin
        // door bit reads low while the pin serves as read gate
        rd_val[`FDP_DIN_DOOR] = state_reg.door_q && !state_reg.cfg[`FDP_CFG_READ_GATE_DIAG];
        rd_val[`FDP_DIN_SYS2] = sys2;
        rd_val[`FDP_DIN_BADSTRAP] = state_reg.strap_bad;
      end else if (rsel == FDP_SEL_ISTAT) begin
        rd_val[`FDP_IRQ_W-1:0] = state_reg.irq_stat;
      end else if (rsel == FDP_SEL_IEN) begin
        rd_val[`FDP_IRQ_W-1:0] = state_reg.irq_en;
      end else if (rsel == FDP_SEL_NONE) begin
        state_next.rresp = `FDP_RESP_SLVERR;
      end
      state_next.rdata = rd_val;
    end
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    state_next.arready = !state_next.rvalid;

    // set wins over a clear in the same cycle
    for (int i = 0; i < `FDP_IRQ_W; i++) begin
      if (set_ev[i]) begin
        state_next.irq_stat[i] = 1'b1;
      end else if (clr_ev[i]) begin
        state_next.irq_stat[i] = 1'b0;
      end
    end
    state_next.pins.irq = |(state_next.irq_stat & state_next.irq_en);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      state_reg.digital_output_reg <= `FDP_DOR_RST;
      state_reg.cfg <= `FDP_CFG_RST;
      state_reg.irq_stat <= `FDP_IRQ_RST;
      state_reg.irq_en <= `FDP_IRQ_RST;
      state_reg.mode <= FDP_MODE_LEGACY;
      state_reg.pins.pp_head_oe_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rresp = state_reg.rresp;
  assign s_axi_rdata = state_reg.rdata;
  assign floppy_dma_req = state_reg.pins.floppy_dma_req;
  assign dma_ack_ok = state_reg.pins.dma_ack_ok;
  assign dma_rd = state_reg.pins.dma_rd;
  assign dma_wr = state_reg.pins.dma_wr;
  assign head_side_select = state_reg.pins.head_side_select;
  assign pp_head_out = state_reg.pins.pp_head_out;
  assign pp_head_oe_n = state_reg.pins.pp_head_oe_n;
  assign read_gate_diag = state_reg.pins.read_gate_diag;
  assign irq = state_reg.pins.irq;

endmodule // fdp_top

/* File: sim/fdp_assertions.sv */
// port-level checks for the floppy pin block
`timescale 1ns/1ps
module fdp_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins
  input wire logic ident_strap,
  input wire logic door_opened_in,
  input wire logic floppy_dma_ack_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic xfer_demand,
  input wire logic floppy_dma_req,
  input wire logic dma_ack_ok,
  input wire logic dma_rd,
  input wire logic dma_wr,
  input wire logic read_gate_diag,
  input wire logic head_side_select,
  input wire logic pp_head_out,
  input wire logic pp_head_oe_n
);
  // mode trusted only a few edges after the straps were taken
  logic [1:0] up_reg;
  logic sys2_reg;
  logic s2_up;
  assign s2_up = up_reg == 2'h3 && sys2_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
    if (aresetn && up_reg == 2'h0) sys2_reg <= !ident_strap;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_req_demand: assert property (floppy_dma_req |-> $past(xfer_demand))
    else $error("request without demand");
  a_req_sys2: assert property (s2_up && xfer_demand |=> floppy_dma_req)
    else $error("request gated in system-2 mode");
  a_ack_sys2: assert property ((s2_up && !floppy_dma_ack_n)[*2] |-> dma_ack_ok)
    else $error("acknowledge ignored in system-2 mode");
  a_ack_low: assert property (dma_ack_ok |-> !$past(floppy_dma_ack_n))
    else $error("acknowledge honoured while high");
  a_rd_qual: assert property (dma_rd == (dma_ack_ok && !$past(host_rd_n)))
    else $error("read strobe not qualified by acknowledge");
  a_wr_qual: assert property (dma_wr == (dma_ack_ok && !$past(host_wr_n)))
    else $error("write strobe not qualified by acknowledge");
  a_gate_diag: assert property (read_gate_diag |-> $past(door_opened_in))
    else $error("read gate without door input");
  a_head_copy: assert property (pp_head_out == (!pp_head_oe_n && head_side_select))
    else $error("shared head pin differs");
  cover property (dma_rd);
  cover property (dma_wr);
  cover property (!pp_head_oe_n && pp_head_out);
  cover property (read_gate_diag);
endmodule // fdp_chk

/* File: sim/fdp_far_model.sv */
// drive and dma controller model facing the floppy pin block
`timescale 1ns/1ps
module fdp_far_model (
  // clock
  input wire logic aclk,
  // bench controls
  input wire logic door_cmd,
  input wire logic pp_door_cmd,
  input wire logic rogue_ack,
  input wire logic to_disk,
  input wire logic [3:0] delay,
  // block pins
  input wire logic floppy_dma_req,
  output logic door_opened_in,
  output logic door_opened_pp_in,
  output logic floppy_dma_ack_n,
  output logic host_rd_n,
  output logic host_wr_n
);
  logic [3:0] wait_reg = 4'h0;
  logic asked, grant;
  assign asked = floppy_dma_req || rogue_ack;
  assign grant = asked && wait_reg >= delay;
  initial begin
    {door_opened_in, door_opened_pp_in} = 2'h0;
    {floppy_dma_ack_n, host_rd_n, host_wr_n} = 3'h7;
  end
  always @(posedge aclk) begin
    door_opened_in <= door_cmd;
    door_opened_pp_in <= pp_door_cmd;
    wait_reg <= !asked ? 4'h0 : wait_reg + {3'h0, wait_reg != 4'hF};
    // ack answers a request or the rogue_ack control, so it stays high during register traffic with neither up
    floppy_dma_ack_n <= !grant;
    host_rd_n <= !(grant && !to_disk);
    host_wr_n <= !(grant && to_disk);
  end
endmodule // fdp_far_model

/* File: sim/fdp_top_tb_top.sv */
// self-checking bench for the floppy pin block
`timescale 1ns/1ps
`include "fdp_params.svh"
`define CHK(n, e, s) chk(n, e, s)
module fdp_top_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic ident_strap = 1'b1, encoding_strap = 1'b1, xfer_demand = 1'b0;
  logic door = 1'b0, pp_door = 1'b0, rogue = 1'b0, to_disk = 1'b0;
  logic [3:0] delay = 4'h2;
  logic door_opened_in, door_opened_pp_in, floppy_dma_ack_n, host_rd_n, host_wr_n;
  logic head_side_select, pp_head_out, pp_head_oe_n, floppy_dma_req, irq;
  logic dma_ack_ok, dma_rd, dma_wr, read_gate_diag;
  int fails = 0, checked = 0;
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  fdp_top dut_u (.*);
  fdp_far_model far_u (.aclk, .door_cmd(door), .pp_door_cmd(pp_door), .rogue_ack(rogue),
    .to_disk, .delay, .floppy_dma_req, .door_opened_in, .door_opened_pp_in,
    .floppy_dma_ack_n, .host_rd_n, .host_wr_n);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // bounded edge wait shared by every handshake loop
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 60) begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] a, d, input logic [1:0] r = `FDP_RESP_OKAY);
    int n;
    n = 0;
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      tick(n);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    `CHK("bresp", r, s_axi_bresp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    int n;
    n = 0;
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    do begin
      tick(n);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    `CHK("rresp", `FDP_RESP_OKAY, s_axi_rresp);
    `CHK("rdata", e, s_axi_rdata);
  endtask
  task automatic wait_ack(input logic w);
    int n;
    n = 0;
    while (dma_ack_ok !== w) tick(n);
  endtask
  task automatic rst(input logic id, en);
    aresetn <= 1'b0;
    ident_strap <= id;
    encoding_strap <= en;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  task automatic t_straps();
    logic [1:0] k;
    for (int i = 0; i < 3; i++) begin
      k = 2'(i);
      rst(k != 2'h2, k != 2'h1);
      rd(`FDP_OFS_DIN, {30'h0, k[0], k[1]});
      rd(`FDP_OFS_ISTAT, {29'h0, k[0], 2'h0});
    end
    rd(`FDP_OFS_CFG, 32'h0);
    // a write without its low byte lane must leave the register alone
    s_axi_wstrb <= 4'h0;
    wr(`FDP_OFS_CFG, 8'h0F);
    s_axi_wstrb <= 4'hF;
    rd(`FDP_OFS_CFG, 32'h0);
    wr(8'h18, 8'h01, `FDP_RESP_SLVERR);
    wr(`FDP_OFS_DIN, 8'hFF);
  endtask
  task automatic t_sys2();
    xfer_demand <= 1'b1;
    wait_ack(1'b1);
    `CHK("req", 1'b1, floppy_dma_req);
    `CHK("dma_rd", 1'b1, dma_rd);
    xfer_demand <= 1'b0;
    wait_ack(1'b0);
    wr(`FDP_OFS_DOR, 8'h08);
    rd(`FDP_OFS_DOR, 32'h0);
  endtask
  task automatic t_legacy();
    xfer_demand <= 1'b1;
    rogue <= 1'b1;
    repeat (5) @(posedge aclk);
    `CHK("req", 1'b0, floppy_dma_req);
    `CHK("ack_ok", 1'b0, dma_ack_ok);
    rogue <= 1'b0;
    delay <= 4'h5;
    to_disk <= 1'b1;
    repeat (2) @(posedge aclk);
    wr(`FDP_OFS_DOR, 8'h08);
    wait_ack(1'b1);
    `CHK("req", 1'b1, floppy_dma_req);
    `CHK("dma_wr", 1'b1, dma_wr);
    xfer_demand <= 1'b0;
    wait_ack(1'b0);
    // read only once the acknowledge is back high
    rd(`FDP_OFS_ISTAT, 32'h2);
  endtask
  task automatic t_door();
    wr(`FDP_OFS_ICLR, 8'h07);
    wr(`FDP_OFS_IEN, 8'h01);
    door <= 1'b1;
    repeat (5) @(posedge aclk);
    `CHK("irq", 1'b1, irq);
    rd(`FDP_OFS_DIN, 32'h80);
    wr(`FDP_OFS_IEN, 8'h00);
    repeat (2) @(posedge aclk);
    `CHK("irq", 1'b0, irq);
    wr(`FDP_OFS_ICLR, 8'h01);
    rd(`FDP_OFS_ISTAT, 32'h0);
    wr(`FDP_OFS_CFG, 8'h01);
    repeat (2) @(posedge aclk);
    `CHK("gate", 1'b1, read_gate_diag);
    rd(`FDP_OFS_DIN, 32'h0);
    door <= 1'b0;
  endtask
  task automatic t_pp();
    wr(`FDP_OFS_CFG, 8'h0A);
    pp_door <= 1'b1;
    repeat (4) @(posedge aclk);
    `CHK("head", 1'b1, head_side_select);
    `CHK("pp_oe_n", 1'b0, pp_head_oe_n);
    `CHK("pp_head", 1'b1, pp_head_out);
    rd(`FDP_OFS_DIN, 32'h80);
    wr(`FDP_OFS_CFG, 8'h06);
    repeat (3) @(posedge aclk);
    `CHK("head", 1'b0, head_side_select);
    `CHK("pp_oe_n", 1'b1, pp_head_oe_n);
    `CHK("pp_head", 1'b0, pp_head_out);
    rd(`FDP_OFS_DIN, 32'h0);
  endtask
  initial begin
    t_straps();
    t_sys2();
    rst(1'b1, 1'b1);
    t_legacy();
    t_door();
    t_pp();
    report_and_stop();
  end
endmodule // fdp_top_tb_top
bind fdp_top fdp_chk chk_u (.*);
